// *** pia_defs.vh ***
/*
  Constants for the priority interrupt arbiter: status word fields, reset
  values, trap vector, vector and stack steps, power-fail window timing.
  Assumes it is included by bare name from every design file.
*/
`ifndef PIA_DEFS_VH
`define PIA_DEFS_VH

// ----------------------------------------------------------------------------
// Status word and levels
// ----------------------------------------------------------------------------
`define PIA_PRI_HI        7
`define PIA_PRI_LO        5
`define PIA_LVL_BASE      1'b1
`define PIA_LVL_LINES     4
`define PIA_SW_RESET      16'h00e0
`define PIA_PC_RESET      16'h0000
`define PIA_SP_RESET      16'h0000

// ----------------------------------------------------------------------------
// Vectors and stack
// ----------------------------------------------------------------------------
`define PIA_PF_VECTOR     16'h0014
`define PIA_VEC_SW_OFS    16'h0002
`define PIA_WORD_STEP     16'h0002

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PIA_CLK_KHZ       10000
`define PIA_PF_WINDOW_US  2000
// Window length in clocks, at counter width
`define PIA_PF_CYCLES     16'h4e20
`define PIA_PF_CNT_W      16

`endif

// *** pia_level_select.v ***
/*
  Picks the highest pending level request above the processor priority.
  Assumes request bit i stands for level four plus i, inputs synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pia_defs.vh"

module pia_level_select (
  // Requests and priority
  input  wire [3:0] levelBusReq,
  input  wire [2:0] curPriority,
  // Pick
  output reg  [3:0] pickOneHot,
  output reg        pickValid
);

  // --------------------------------------------------------------------------
  // Level compare
  // --------------------------------------------------------------------------
  function aboveLevel;
    input [1:0] lineIdx;
    input [2:0] pri;
    begin
      aboveLevel = ({`PIA_LVL_BASE, lineIdx} > pri);
    end
  endfunction

  always @* begin
    pickOneHot = 4'h0;
    pickValid  = 1'b0;
    if (levelBusReq[3] && aboveLevel(2'h3, curPriority)) begin
      pickOneHot = 4'h8;
    end else if (levelBusReq[2] && aboveLevel(2'h2, curPriority)) begin
      pickOneHot = 4'h4;
    end else if (levelBusReq[1] && aboveLevel(2'h1, curPriority)) begin
      pickOneHot = 4'h2;
    end else if (levelBusReq[0] && aboveLevel(2'h0, curPriority)) begin
      pickOneHot = 4'h1;
    end
    pickValid = (pickOneHot != 4'h0);
  end

endmodule
`default_nettype wire

// *** pia_pf_timer.v ***
/*
  Power-fail save window timer: opens on a start pulse, closes after CYCLES.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pia_defs.vh"

module pia_pf_timer #(
  parameter [`PIA_PF_CNT_W-1:0] CYCLES = `PIA_PF_CYCLES
) (
  // Clock and reset
  input  wire clk,
  input  wire srst,
  // Control
  input  wire start,
  output reg  windowOpen
);

  reg [`PIA_PF_CNT_W-1:0] count;

  always @(posedge clk) begin
    if (srst) begin
      count      <= {`PIA_PF_CNT_W{1'b0}};
      windowOpen <= 1'b0;
    end else if (start) begin
      count      <= CYCLES;
      windowOpen <= 1'b1;
    end else if (windowOpen) begin
      count <= count - {{(`PIA_PF_CNT_W-1){1'b0}}, 1'b1};
      if (count <= {{(`PIA_PF_CNT_W-1){1'b0}}, 1'b1}) begin
        windowOpen <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** pia_arbiter.v ***
/*
  Processor-side bus request arbiter and vectored interrupt sequencer.
  Holds program counter, status word and stack pointer, grants the bus to
  direct-transfer and level requesters, runs vector fetch, save, push, return
  and the power traps over a simple handshaked memory port.
  Assumes all inputs synchronous to clk; the grant daisy chain and the shared
  bus lie outside; the core pulses its cycle and instruction boundaries.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pia_defs.vh"

// Summary of operation
// - Priority is status word bits 7..5, program loadable to eight levels.
// - Level requests at or below processor priority are never granted.
// - Highest pending level above processor priority is the one granted.
// - Five request lines; direct-transfer line outranks the four level lines.
// - Level lines cover levels seven to four; their master may interrupt.
// - Direct-transfer grants happen between bus cycles, mid-instruction.
// - No grant between read and write halves of read-modify-write.
// - Within one line the nearest device wins via the grant chain.
// - Requests and priority are sampled while transfers still run.
// - Interrupt service starts by handing the bus to the requester.
// - New counter from vector, new status word from vector plus two.
// - Old status word and counter are copied to temporaries first.
// - Old status word then counter are pushed, then service begins.
// - Return pops counter then status word from the stack top.
// - Service routine is interruptible once both old words are pushed.
// - Power fail traps through the fixed vector; two ms save window.
// - Power return traps through the same fixed vector.
// - At priority seven no device interrupt is accepted.
module pia_arbiter #(
  parameter [`PIA_PF_CNT_W-1:0] PF_WINDOW_CYCLES = `PIA_PF_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Bus requests and grants
  input  wire        dtReq,
  input  wire [3:0]  levelBusReq,
  output reg         dtGrant,
  output reg  [3:0]  levelGrant,
  input  wire        selAck,
  input  wire        busBusy,
  // Interrupt command from bus master
  input  wire        intCmd,
  input  wire [15:0] intVector,
  // Core timing
  input  wire        cpuCycleEnd,
  input  wire        cpuInstrEnd,
  input  wire        cpuRmwLock,
  // Core register loads and return
  input  wire        swLoad,
  input  wire [15:0] swLoadData,
  input  wire        pcLoad,
  input  wire [15:0] pcLoadData,
  input  wire        spLoad,
  input  wire [15:0] spLoadData,
  input  wire        rtiReq,
  // Power events
  input  wire        powerFail,
  input  wire        powerUp,
  // Memory port
  output reg         memReq,
  output reg         memWrite,
  output reg  [15:0] memAddr,
  output reg  [15:0] memWdata,
  input  wire [15:0] memRdata,
  input  wire        memDone,
  // State
  output reg  [15:0] programCounter,
  output reg  [15:0] processorStatusWord,
  output reg  [15:0] stackPointer,
  output reg         seqBusy,
  output reg         pfWindowOpen
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [2:0] G_IDLE  = 3'b001;
  localparam [2:0] G_OFFER = 3'b010;
  localparam [2:0] G_HELD  = 3'b100;

  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_SAVE = 8'h02;
  localparam [7:0] S_FPC  = 8'h04;
  localparam [7:0] S_FPS  = 8'h08;
  localparam [7:0] S_PSHS = 8'h10;
  localparam [7:0] S_PSHC = 8'h20;
  localparam [7:0] S_POPC = 8'h40;
  localparam [7:0] S_POPS = 8'h80;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg  [2:0]  grantState;
  reg         heldIsLevel;
  reg  [3:0]  pickReg;
  reg  [7:0]  seqState;
  reg  [15:0] tmpPc;
  reg  [15:0] tmpSw;
  reg  [15:0] vecBase;
  reg  [15:0] vecLatch;
  reg         intPend;
  reg         pfPend;
  reg         puPend;
  reg  [15:0] stepAddr;
  reg  [15:0] stepData;
  reg         stepWrite;
  reg         stepIsMem;
  wire [3:0]  pickOneHot;
  wire        pickValid;
  wire [3:0]  pickNow;
  wire        seqIdle;
  wire        startPf;
  wire        startPu;
  wire        startInt;
  wire        startRti;
  wire        intTake;
  wire        pfWindow;

  // --------------------------------------------------------------------------
  // Level pick
  // --------------------------------------------------------------------------
  pia_level_select uSelect (
    .levelBusReq (levelBusReq),
    .curPriority (processorStatusWord[`PIA_PRI_HI:`PIA_PRI_LO]),
    .pickOneHot  (pickOneHot),
    .pickValid   (pickValid)
  );

  assign pickNow = pickOneHot & {4{pickValid}};

  // Winner kept up to date while the bus is busy
  always @(posedge clk) begin
    if (srst) begin
      pickReg <= 4'h0;
    end else begin
      pickReg <= pickNow;
    end
  end

  // --------------------------------------------------------------------------
  // Grant control
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      grantState  <= G_IDLE;
      heldIsLevel <= 1'b0;
      dtGrant     <= 1'b0;
      levelGrant  <= 4'h0;
    end else begin
      case (grantState)
        G_IDLE: begin
          if (dtReq && cpuCycleEnd && !cpuRmwLock && !memReq) begin
            dtGrant     <= 1'b1;
            heldIsLevel <= 1'b0;
            grantState  <= G_OFFER;
          end else if (((pickReg & pickNow) != 4'h0) && cpuInstrEnd && !cpuRmwLock &&
                       seqIdle && !memReq) begin
            levelGrant  <= pickReg & pickNow;
            heldIsLevel <= 1'b1;
            grantState  <= G_OFFER;
          end
        end
        G_OFFER: begin
          // Grant travels the chain; nearest requester on the line takes it
          if (selAck) begin
            dtGrant    <= 1'b0;
            levelGrant <= 4'h0;
            grantState <= G_HELD;
          end else if ((dtGrant && !dtReq) ||
                       (!dtGrant && ((levelGrant & levelBusReq) == 4'h0))) begin
            dtGrant    <= 1'b0;
            levelGrant <= 4'h0;
            grantState <= G_IDLE;
          end
        end
        G_HELD: begin
          if (!busBusy && !selAck) begin
            grantState <= G_IDLE;
          end
        end
        default: begin
          dtGrant    <= 1'b0;
          levelGrant <= 4'h0;
          grantState <= G_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Pending events
  // --------------------------------------------------------------------------
  assign intTake  = (grantState == G_HELD) && heldIsLevel && intCmd;
  assign seqIdle  = (seqState == S_IDLE);
  assign startPf  = seqIdle && pfPend;
  assign startPu  = seqIdle && !pfPend && puPend;
  assign startInt = seqIdle && !pfPend && !puPend && intPend;
  assign startRti = seqIdle && !pfPend && !puPend && !intPend && rtiReq;

  // New event wins over the clear in the same cycle
  always @(posedge clk) begin
    if (srst) begin
      intPend  <= 1'b0;
      vecLatch <= 16'h0000;
      pfPend   <= 1'b0;
      puPend   <= 1'b0;
    end else begin
      if (intTake) begin
        intPend  <= 1'b1;
        vecLatch <= intVector;
      end else if (startInt) begin
        intPend <= 1'b0;
      end
      if (powerFail) begin
        pfPend <= 1'b1;
      end else if (startPf) begin
        pfPend <= 1'b0;
      end
      if (powerUp) begin
        puPend <= 1'b1;
      end else if (startPu) begin
        puPend <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power-fail window
  // --------------------------------------------------------------------------
  pia_pf_timer #(
    .CYCLES (PF_WINDOW_CYCLES)
  ) uPfTimer (
    .clk        (clk),
    .srst       (srst),
    .start      (startPf),
    .windowOpen (pfWindow)
  );

  always @(posedge clk) begin
    if (srst) begin
      pfWindowOpen <= 1'b0;
      seqBusy      <= 1'b0;
    end else begin
      pfWindowOpen <= pfWindow;
      seqBusy      <= !seqIdle;
    end
  end

  // --------------------------------------------------------------------------
  // Memory step for the current state
  // --------------------------------------------------------------------------
  always @* begin
    stepAddr  = 16'h0000;
    stepData  = 16'h0000;
    stepWrite = 1'b0;
    stepIsMem = 1'b1;
    case (seqState)
      S_FPC:  stepAddr = vecBase;
      S_FPS:  stepAddr = vecBase + `PIA_VEC_SW_OFS;
      S_PSHS: begin
        stepAddr  = stackPointer - `PIA_WORD_STEP;
        stepData  = tmpSw;
        stepWrite = 1'b1;
      end
      S_PSHC: begin
        stepAddr  = stackPointer - `PIA_WORD_STEP;
        stepData  = tmpPc;
        stepWrite = 1'b1;
      end
      S_POPC: stepAddr = stackPointer;
      S_POPS: stepAddr = stackPointer;
      default: stepIsMem = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Interrupt and trap sequencer
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      seqState            <= S_IDLE;
      tmpPc               <= 16'h0000;
      tmpSw               <= 16'h0000;
      vecBase             <= 16'h0000;
      memReq              <= 1'b0;
      memWrite            <= 1'b0;
      memAddr             <= 16'h0000;
      memWdata            <= 16'h0000;
      programCounter      <= `PIA_PC_RESET;
      processorStatusWord <= `PIA_SW_RESET;
      stackPointer        <= `PIA_SP_RESET;
    end else if (seqIdle) begin
      if (startPf || startPu) begin
        vecBase  <= `PIA_PF_VECTOR;
        seqState <= S_SAVE;
      end else if (startInt) begin
        vecBase  <= vecLatch;
        seqState <= S_SAVE;
      end else if (startRti) begin
        seqState <= S_POPC;
      end else begin
        if (swLoad) begin
          processorStatusWord <= swLoadData;
        end
        if (pcLoad) begin
          programCounter <= pcLoadData;
        end
        if (spLoad) begin
          stackPointer <= spLoadData;
        end
      end
    end else if (seqState == S_SAVE) begin
      tmpPc    <= programCounter;
      tmpSw    <= processorStatusWord;
      seqState <= S_FPC;
    end else if (stepIsMem) begin
      if (!memReq && (grantState == G_IDLE)) begin
        memReq   <= 1'b1;
        memWrite <= stepWrite;
        memAddr  <= stepAddr;
        memWdata <= stepData;
      end else if (memReq && memDone) begin
        memReq   <= 1'b0;
        memWrite <= 1'b0;
        case (seqState)
          S_FPC: begin
            programCounter <= memRdata;
            seqState       <= S_FPS;
          end
          S_FPS: begin
            processorStatusWord <= memRdata;
            seqState            <= S_PSHS;
          end
          S_PSHS: begin
            stackPointer <= stepAddr;
            seqState     <= S_PSHC;
          end
          S_PSHC: begin
            stackPointer <= stepAddr;
            seqState     <= S_IDLE;
          end
          S_POPC: begin
            programCounter <= memRdata;
            stackPointer   <= stackPointer + `PIA_WORD_STEP;
            seqState       <= S_POPS;
          end
          S_POPS: begin
            processorStatusWord <= memRdata;
            stackPointer        <= stackPointer + `PIA_WORD_STEP;
            seqState            <= S_IDLE;
          end
          default: seqState <= S_IDLE;
        endcase
      end
    end else begin
      seqState <= S_IDLE;
    end
  end

endmodule
`default_nettype wire

// *** pia_arbiter_assertions.sv ***
/*
  Concurrent checks on the pia_arbiter ports, bound into every instance.
  Assumes one clock, srst synchronous active high, all outputs registered.
*/
`timescale 1ns/1ps
`default_nettype none

module pia_arbiter_chk #(
  parameter int PF_WINDOW_CYCLES = 20
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Requests and grants
  input wire logic        dtReq,
  input wire logic [3:0]  levelBusReq,
  input wire logic        dtGrant,
  input wire logic [3:0]  levelGrant,
  input wire logic        selAck,
  input wire logic        busBusy,
  input wire logic        cpuCycleEnd,
  input wire logic        cpuRmwLock,
  // Memory port and state
  input wire logic        memReq,
  input wire logic        memWrite,
  input wire logic [15:0] memAddr,
  input wire logic        memDone,
  input wire logic [15:0] processorStatusWord,
  input wire logic [15:0] stackPointer,
  input wire logic        pfWindowOpen
);
  logic        anyGrant;
  logic [2:0]  grantLvl;
  logic [15:0] pfLen;

  assign anyGrant = dtGrant | (|levelGrant);
  assign grantLvl = levelGrant[3] ? 3'h7 : levelGrant[2] ? 3'h6 : levelGrant[1] ? 3'h5 : 3'h4;

  // Length of the open save window
  always_ff @(posedge clk) begin
    if (srst || !pfWindowOpen) begin
      pfLen <= 16'h0000;
    end else begin
      pfLen <= pfLen + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_ONE_GRANT: assert property ($onehot0({dtGrant, levelGrant}))
    else $error("more than one grant active");
  AST_RMW_NO_GRANT: assert property ($rose(anyGrant) |-> !$past(cpuRmwLock))
    else $error("grant given inside read-modify-write");
  AST_DT_BETWEEN_CYCLES: assert property ($rose(dtGrant) |-> $past(dtReq) && $past(cpuCycleEnd))
    else $error("direct-transfer grant not at a cycle boundary");
  AST_LVL_ABOVE_PRI: assert property ($rose(|levelGrant) |-> grantLvl > $past(processorStatusWord[7:5]))
    else $error("level grant not above processor priority");
  AST_LVL_REQUESTED: assert property ($rose(|levelGrant) |-> |($past(levelBusReq) & levelGrant))
    else $error("level grant on a line with no request");
  AST_DT_OUTRANKS: assert property ($rose(|levelGrant) |-> !$past(dtReq && cpuCycleEnd && !cpuRmwLock && !memReq))
    else $error("level granted over a direct-transfer request");
  AST_REARB_AFTER_RELEASE: assert property ($rose(anyGrant) |-> !$past(selAck) && !$past(busBusy))
    else $error("new grant before bus release");
  AST_GRANT_DROPS: assert property (anyGrant && selAck |=> !anyGrant)
    else $error("grant held after selection acknowledge");
  AST_MEM_HOLD: assert property (memReq && !memDone |=> memReq && $stable(memAddr) && $stable(memWrite))
    else $error("memory request changed before done");
  AST_PUSH_BELOW_SP: assert property ($rose(memReq) && memWrite |-> memAddr == stackPointer - 16'h0002)
    else $error("push address not below stack pointer");
  AST_PF_WINDOW_LEN: assert property ($fell(pfWindowOpen) |-> pfLen >= PF_WINDOW_CYCLES - 1 && pfLen <= PF_WINDOW_CYCLES + 1)
    else $error("power-fail window length wrong");

  cover property ($rose(dtGrant));
  cover property ($rose(|levelGrant));
  cover property ($rose(memReq) && memWrite);
  cover property ($fell(pfWindowOpen));
endmodule

bind pia_arbiter pia_arbiter_chk #(.PF_WINDOW_CYCLES(PF_WINDOW_CYCLES)) u_chk (
  .clk(clk), .srst(srst), .dtReq(dtReq), .levelBusReq(levelBusReq), .dtGrant(dtGrant),
  .levelGrant(levelGrant), .selAck(selAck), .busBusy(busBusy), .cpuCycleEnd(cpuCycleEnd),
  .cpuRmwLock(cpuRmwLock), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memDone(memDone),
  .processorStatusWord(processorStatusWord), .stackPointer(stackPointer), .pfWindowOpen(pfWindowOpen)
);

`default_nettype wire

// *** pia_mem_model.sv ***
/*
  Word memory answering the arbiter's memory port after a set latency.
  Assumes addresses below 16'h0080; holds vector words for the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module pia_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Memory port
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic      [15:0] memRdata,
  output logic             memDone,
  // Answer delay in cycles
  input  wire logic [2:0]  latency
);
  logic [15:0] mem [0:63];
  logic [2:0]  waitCnt;

  initial begin
    mem[32] = 16'h1000;
    mem[33] = 16'h00c0;
    mem[40] = 16'h2000;
    mem[41] = 16'h00e0;
    mem[10] = 16'h3000;
    mem[11] = 16'h00e0;
  end

  // Read data is valid only with done; otherwise it toggles
  always @(posedge clk) begin
    if (srst) begin
      memDone  <= 1'b0;
      waitCnt  <= 3'h0;
      memRdata <= 16'h5a5a;
    end else if (memReq && !memDone && waitCnt >= latency) begin
      memDone  <= 1'b1;
      waitCnt  <= 3'h0;
      memRdata <= mem[memAddr[6:1]];
      if (memWrite) begin
        mem[memAddr[6:1]] <= memWdata;
      end
    end else begin
      memDone  <= 1'b0;
      waitCnt  <= (memReq && !memDone) ? waitCnt + 3'h1 : 3'h0;
      memRdata <= ~memRdata;
    end
  end
endmodule

`default_nettype wire

// *** pia_arbiter_tb.sv ***
/*
  Self-checking bench for pia_arbiter: grants, interrupts, nesting, traps.
  Assumes pia_mem_model on the memory port and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none

module pia_arbiter_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        dtReq = 1'b0, selAck = 1'b0, busBusy = 1'b0, intCmd = 1'b0, rtiReq = 1'b0;
  logic        cpuCycleEnd = 1'b0, cpuInstrEnd = 1'b0, cpuRmwLock = 1'b0, powerFail = 1'b0;
  logic        swLoad = 1'b0, pcLoad = 1'b0, spLoad = 1'b0, powerUp = 1'b0;
  logic [3:0]  levelBusReq = 4'h0;
  logic [15:0] intVector = 16'h0000, swLoadData = 16'h0000, pcLoadData = 16'h0000, spLoadData = 16'h0000;
  logic [2:0]  latency = 3'h0;
  logic        dtGrant, memReq, memWrite, memDone, seqBusy, pfWindowOpen;
  logic [3:0]  levelGrant;
  logic [15:0] memAddr, memWdata, memRdata, programCounter, processorStatusWord, stackPointer;
  int          n_errors = 0;
  int          checks_done = 0;

  always #50 clk = ~clk;

  pia_arbiter #(.PF_WINDOW_CYCLES(16'h0014)) uut (
    .clk(clk), .srst(srst), .dtReq(dtReq), .levelBusReq(levelBusReq), .dtGrant(dtGrant),
    .levelGrant(levelGrant), .selAck(selAck), .busBusy(busBusy), .intCmd(intCmd), .intVector(intVector),
    .cpuCycleEnd(cpuCycleEnd), .cpuInstrEnd(cpuInstrEnd), .cpuRmwLock(cpuRmwLock), .swLoad(swLoad),
    .swLoadData(swLoadData), .pcLoad(pcLoad), .pcLoadData(pcLoadData), .spLoad(spLoad),
    .spLoadData(spLoadData), .rtiReq(rtiReq), .powerFail(powerFail), .powerUp(powerUp), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memDone(memDone),
    .programCounter(programCounter), .processorStatusWord(processorStatusWord),
    .stackPointer(stackPointer), .seqBusy(seqBusy), .pfWindowOpen(pfWindowOpen)
  );

  pia_mem_model mdl (
    .clk(clk), .srst(srst), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memDone(memDone), .latency(latency)
  );

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Opens cycle boundaries and waits for a grant; zero means none may come
  task automatic await_grant(input logic [4:0] exp);
    int i;
    @(posedge clk);
    cpuCycleEnd <= 1'b1;
    cpuInstrEnd <= 1'b1;
    for (i = 0; i < 20 && {dtGrant, levelGrant} === 5'h00; i++) begin
      @(negedge clk);
    end
    check(16'({dtGrant, levelGrant}), 16'(exp));
    if (i >= 20 && exp != 5'h00) begin
      test_done();
    end
  endtask

  // Granted master takes the bus, optionally interrupts, then releases
  task automatic serve(input logic doInt, input logic [15:0] vec);
    @(posedge clk);
    cpuCycleEnd <= 1'b0;
    cpuInstrEnd <= 1'b0;
    selAck <= 1'b1;
    busBusy <= 1'b1;
    dtReq <= 1'b0;
    levelBusReq <= 4'h0;
    intCmd <= doInt;
    intVector <= vec;
    repeat (2) @(posedge clk);
    selAck <= 1'b0;
    busBusy <= 1'b0;
    intCmd <= 1'b0;
    intVector <= ~vec;
    @(negedge clk);
    check(16'({dtGrant, levelGrant}), 16'h0000);
  endtask

  task automatic wait_seq;
    int i;
    for (i = 0; i < 10 && seqBusy !== 1'b1; i++) begin
      @(negedge clk);
    end
    check(16'(seqBusy), 16'h0001);
    if (seqBusy !== 1'b1) begin
      test_done();
    end
    for (i = 0; i < 300 && seqBusy !== 1'b0; i++) begin
      @(negedge clk);
    end
    check(16'(seqBusy), 16'h0000);
    if (seqBusy !== 1'b0) begin
      test_done();
    end
  endtask

  task automatic expect_state(input logic [15:0] pc, input logic [15:0] sw, input logic [15:0] sp);
    check(programCounter, pc);
    check(processorStatusWord, sw);
    check(stackPointer, sp);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic test_reset;
    @(negedge clk);
    expect_state(16'h0000, 16'h00e0, 16'h0000);
    @(posedge clk);
    levelBusReq <= 4'hf;
    await_grant(5'h00);
    @(posedge clk);
    levelBusReq <= 4'h0;
  endtask

  task automatic load_regs(input logic [15:0] sw, input logic [15:0] pc, input logic [15:0] sp);
    @(posedge clk);
    {swLoad, pcLoad, spLoad} <= 3'h7;
    swLoadData <= sw;
    pcLoadData <= pc;
    spLoadData <= sp;
    @(posedge clk);
    {swLoad, pcLoad, spLoad} <= 3'h0;
    @(negedge clk);
    expect_state(pc, sw, sp);
  endtask

  task automatic test_prio;
    @(posedge clk);
    levelBusReq <= 4'h3;
    await_grant(5'h00);
    @(posedge clk);
    levelBusReq <= 4'h7;
    await_grant(5'h04);
    serve(1'b0, 16'h0000);
  endtask

  task automatic test_dt;
    @(posedge clk);
    dtReq <= 1'b1;
    levelBusReq <= 4'h8;
    cpuRmwLock <= 1'b1;
    await_grant(5'h00);
    @(posedge clk);
    cpuRmwLock <= 1'b0;
    await_grant(5'h10);
    serve(1'b0, 16'h0000);
  endtask

  task automatic test_int;
    @(posedge clk);
    levelBusReq <= 4'h4;
    await_grant(5'h04);
    serve(1'b1, 16'h0040);
    wait_seq();
    expect_state(16'h1000, 16'h00c0, 16'h007c);
    check(mdl.mem[63], 16'h00a0);
    check(mdl.mem[62], 16'h0100);
  endtask

  task automatic test_nest;
    @(posedge clk);
    latency <= 3'h3;
    levelBusReq <= 4'h4;
    await_grant(5'h00);
    @(posedge clk);
    levelBusReq <= 4'h8;
    await_grant(5'h08);
    serve(1'b1, 16'h0050);
    wait_seq();
    expect_state(16'h2000, 16'h00e0, 16'h0078);
    check(mdl.mem[61], 16'h00c0);
    check(mdl.mem[60], 16'h1000);
    @(posedge clk);
    rtiReq <= 1'b1;
    @(posedge clk);
    rtiReq <= 1'b0;
    wait_seq();
    expect_state(16'h1000, 16'h00c0, 16'h007c);
    latency <= 3'h0;
  endtask

  task automatic test_power;
    int i;
    @(posedge clk);
    powerFail <= 1'b1;
    @(posedge clk);
    powerFail <= 1'b0;
    wait_seq();
    check(16'(pfWindowOpen), 16'h0001);
    expect_state(16'h3000, 16'h00e0, 16'h0078);
    for (i = 0; i < 40 && pfWindowOpen !== 1'b0; i++) begin
      @(negedge clk);
    end
    check(16'(pfWindowOpen), 16'h0000);
    if (pfWindowOpen !== 1'b0) begin
      test_done();
    end
    @(posedge clk);
    powerUp <= 1'b1;
    @(posedge clk);
    powerUp <= 1'b0;
    wait_seq();
    expect_state(16'h3000, 16'h00e0, 16'h0074);
    check(mdl.mem[58], 16'h3000);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    test_reset();
    load_regs(16'h00a0, 16'h0100, 16'h0080);
    test_prio();
    test_dt();
    test_int();
    test_nest();
    test_power();
    test_done();
  end
endmodule

`default_nettype wire
